// *** bench/ledseq_panel.sv ***
// Front-panel model: the address DIP switch bank seen by the sequencer.
`timescale 1ns/1ps
module ledseq_panel (
    input  wire logic [7:0] dip_set,
    input  wire logic       clk,
    output logic      [7:0] addr_switch
);
    // Switches only move on a clock edge, as a hand on the bank would between samples.
    always @(posedge clk) begin
        addr_switch <= dip_set;
    end
endmodule : ledseq_panel

// *** bench/ledseq_top_sva.sv ***
// Concurrent checks on the LED sequencer ports.
`timescale 1ns/1ps
module ledseq_top_sva #(
    parameter int unsigned ADDR_CYCLES = 10
) (
    input wire logic                     clk,
    input wire logic                     reset_n,
    input wire logic                     wb_cyc_i,
    input wire logic                     wb_stb_i,
    input wire logic                     wb_we_i,
    input wire logic [7:0]               wb_adr_i,
    input wire logic [3:0]               wb_sel_i,
    input wire logic [31:0]              wb_dat_i,
    input wire logic                     wb_ack_o,
    input wire logic [7:0]               addr_switch,
    input wire ledseq_pkg::ledseq_chan_s chan_status,
    input wire ledseq_pkg::ledseq_leds_s leds
);
    logic        seen_q, done_q, fell_q, cfg_q;
    logic [31:0] cnt_q;
    wire post = done_q | (seen_q & (leds.amber == 8'h00));
    wire in_addr = post & leds.fault & ~fell_q & (leds.red != 8'h00);
    wire cwr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0]
        & (wb_adr_i == ledseq_pkg::CTRL_OFFS);
    function automatic logic [7:0] nxt(input logic [7:0] p);
        return {p[6:0], (p == 8'h00) | ((p != 8'hff) & p[0])};
    endfunction : nxt
    // Phase trackers rebuilt from the LEDs and CTRL bus writes, so no internal state is peeked at.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {seen_q, done_q, fell_q, cfg_q} <= 4'h0;
            cnt_q <= 32'h0;
        end else begin
            seen_q <= seen_q | (leds.amber != 8'h00);
            done_q <= post;
            fell_q <= fell_q | (post & ~leds.fault);
            cnt_q  <= cnt_q + {31'h0, in_addr};
            if (cwr) cfg_q <= wb_dat_i[0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_PU_LIT: assert property (
        $past(reset_n) && !post |-> leds.power && leds.fault) else $error("power-up lit");
    AST_WALK_RED: assert property (
        !seen_q && leds.red != $past(leds.red) |-> leds.red == nxt($past(leds.red)))
        else $error("red walk step");
    AST_WALK_AMB: assert property (
        seen_q && !done_q && leds.amber != $past(leds.amber)
        |-> leds.amber == nxt($past(leds.amber)) && leds.red == 8'h00) else $error("amber walk");
    AST_ADDR_HOLD: assert property (
        in_addr && $past(in_addr) |-> $stable(leds.red)) else $error("address moved");
    AST_ADDR_LEN: assert property (
        post && !fell_q && $fell(leds.fault) |-> cnt_q == ADDR_CYCLES) else $error("addr time");
    AST_POWER: assert property (fell_q |-> leds.power) else $error("power off");
    AST_UNCFG: assert property (
        fell_q && !cfg_q && !$past(cfg_q) |-> leds.red == 8'h00
        && (leds.amber == 8'h00 || leds.amber == 8'hff)) else $error("unconfigured display");
    AST_WDOG: assert property (
        $past(fell_q) && $past(chan_status.watchdog_fail) |-> leds.fault) else $error("wdog");
    AST_RED_RUN: assert property (
        fell_q && cfg_q && $past(cfg_q) |-> leds.red == $past(chan_status.active))
        else $error("red run");
    AST_AMB_FAULT: assert property (
        fell_q && cfg_q && $past(cfg_q) |-> (leds.amber & $past(chan_status.fault))
        == $past(chan_status.fault)) else $error("amber fault");
    COV_ADDR: cover property (in_addr);
    COV_RUN: cover property (fell_q && cfg_q && leds.amber != 8'h00);
    COV_FAULT: cover property (fell_q && leds.fault);
endmodule : ledseq_top_sva
bind ledseq_top ledseq_top_sva #(.ADDR_CYCLES(ADDR_CYCLES)) u_sva (.clk(clk), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .addr_switch(addr_switch), .chan_status(chan_status), .leds(leds));

// *** bench/tb.sv ***
// Self-checking bench for the LED sequencer: walk, address, bus and run displays.
`timescale 1ns/1ps
module tb;
    localparam int unsigned B = 3;
    localparam int unsigned A = 10;
    logic                     clk = 1'b0, reset_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic                     ce = 1'b1;
    logic [3:0]               sel = 4'hf;
    logic [7:0]               adr = 8'h00, dip = 8'h01, sw, av;
    logic [31:0]              wdat = 32'h0, rdat, dato;
    logic                     ack;
    ledseq_pkg::ledseq_chan_s cs = '0;
    ledseq_pkg::ledseq_leds_s leds;
    int                       err_total = 0, samples_checked = 0;
    ledseq_top #(.STEP_CYCLES(4), .BLINK_CYCLES(B), .ADDR_CYCLES(A)) u_ledseq_top (
        .clk(clk), .reset_n(reset_n), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato),
        .wb_ack_o(ack), .addr_switch(sw), .chan_status(cs), .leds(leds));
    ledseq_panel u_ledseq_panel (.dip_set(dip), .clk(clk), .addr_switch(sw));
    always #10 clk = ~clk;
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        rdat = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            chk(32'h0, 32'h1, "bus timeout");
            final_report();
        end
    endtask : wb
    function automatic ledseq_pkg::ledseq_leds_s exp_led(input int i, input logic [7:0] a);
        ledseq_pkg::ledseq_leds_s r;
        r = '0;
        r.power = 1'b1;
        r.fault = 1'b1;
        if (i >= 1 && i <= 8) r.red = 8'hff >> (8 - i);
        if (i >= 9 && i <= 16) r.red = 8'hff << (i - 8);
        if (i >= 17 && i <= 24) r.amber = 8'hff >> (24 - i);
        if (i >= 25 && i <= 32) r.amber = 8'hff << (i - 24);
        if (i == 33) r.red = a;
        return r;
    endfunction : exp_led
    // Resets, then follows every LED change; the switches move mid-display on purpose.
    task automatic powerup(input logic [7:0] a);
        ledseq_pkg::ledseq_leds_s p;
        int i, k;
        @(posedge clk);
        dip <= a;
        reset_n <= 1'b0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        p = '0;
        i = 0;
        for (k = 0; k < 4000 && i < 34; k++) begin
            @(negedge clk);
            if (leds !== p) begin
                chk(32'(leds), 32'(exp_led(i, a)), "power-up pattern");
                p = leds;
                i++;
            end
        end
        chk(32'(i), 32'h22, "power-up steps");
        @(posedge clk);
        dip <= ~a;
        for (k = 0; k < 100 && leds.fault === 1'b1; k++) begin
            @(negedge clk);
            if (leds.fault === 1'b1) chk(32'(leds.red), 32'(a), "address held");
        end
        chk(32'(leds.fault), 32'h0, "fault after address");
        chk(32'(k), 32'(A), "address time");
    endtask : powerup
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        ledseq_pkg::ledseq_chan_s r;
        ledseq_pkg::ledseq_leds_s p;
        logic [7:0] s0, s1;
        int k, j;
        void'($urandom(38));
        av = 8'h01 | 8'($urandom());
        powerup(av);
        {s0, s1} = 16'h0;
        for (k = 0; k < 4 * B; k++) begin
            @(negedge clk);
            chk(32'({leds.power, leds.red}), 32'h100, "unconfigured red");
            s0 |= ~leds.amber;
            s1 |= leds.amber;
        end
        chk(32'({s0, s1}), 32'hffff, "unconfigured flash");
        // The blink toggles every B cycles, so a frozen window of 2*B cycles must show no change.
        @(posedge clk);
        ce <= 1'b0;
        repeat (2) @(negedge clk);
        p = leds;
        for (k = 0; k < 2 * B; k++) begin
            @(negedge clk);
            chk(32'(leds), 32'(p), "frozen by ce");
        end
        @(posedge clk);
        ce <= 1'b1;
        wb(1'b0, ledseq_pkg::STATUS_OFFS, 32'h0, 4'hf);
        chk(rdat, {16'h0, av, 8'h04}, "status");
        wb(1'b0, 8'h0c, 32'h0, 4'hf);
        chk(rdat, 32'h0, "unmapped read");
        wb(1'b1, ledseq_pkg::CTRL_OFFS, 32'h1, 4'hf);
        wb(1'b0, ledseq_pkg::CTRL_OFFS, 32'h0, 4'hf);
        chk(rdat, 32'h1, "ctrl readback");
        wb(1'b1, ledseq_pkg::CTRL_OFFS, 32'h0, 4'he);
        wb(1'b0, ledseq_pkg::CTRL_OFFS, 32'h0, 4'hf);
        chk(rdat, 32'h1, "ctrl lane masked");
        for (k = 0; k < 24; k++) begin
            r = 25'($urandom());
            r.unconfigured = 8'h00;
            @(posedge clk);
            cs <= r;
            repeat (4) @(negedge clk);
            chk(32'(leds.red), 32'(r.active), "run red");
            chk(32'(leds.fault), 32'(r.watchdog_fail), "run fault");
            chk(32'(leds.amber), 32'(r.fault), "run amber");
        end
        for (j = 0; j < 2; j++) begin
            wb(1'b1, ledseq_pkg::CTRL_OFFS, j ? 32'h5 : 32'h1, 4'hf);
            cs <= '{1'b0, 8'h00, 8'h81, j ? 8'h00 : 8'h5a};
            {s0, s1} = 16'h0;
            repeat (2) @(negedge clk);
            for (k = 0; k < 4 * B; k++) begin
                @(negedge clk);
                s0 |= ~leds.amber;
                s1 |= leds.amber;
            end
            chk(32'({s1, s0}), j ? 32'hff7e : 32'hdb7e, "amber blink");
        end
        wb(1'b1, ledseq_pkg::CTRL_OFFS, 32'h3, 4'hf);
        repeat (3) @(negedge clk);
        chk(32'({leds.power, leds.fault}), 32'h3, "disabled fault");
        wb(1'b0, ledseq_pkg::LEDS_OFFS, 32'h0, 4'hf);
        chk(rdat, 32'h0003_0081, "leds register");
        powerup(8'h80 | 8'($urandom()));
        final_report();
    end
endmodule : tb

// *** hdl/ledseq_pkg.sv ***
// Shared constants and carriers for the front-panel LED sequencer.
package ledseq_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned STEP_TIME_MS  = 100;
    localparam int unsigned BLINK_TIME_MS = 250;
    localparam int unsigned ADDR_TIME_MS  = 2000;
    localparam int unsigned MS_DIV        = 1000;
    localparam int unsigned STEP_CYC      = STEP_TIME_MS * (CLK_HZ / MS_DIV);
    localparam int unsigned BLINK_CYC     = BLINK_TIME_MS * (CLK_HZ / MS_DIV);
    localparam int unsigned ADDR_CYC      = ADDR_TIME_MS * (CLK_HZ / MS_DIV);

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int unsigned NUM_CHAN = 8;
    localparam int unsigned NUM_LEDS = 18;
    localparam int unsigned TMR_W    = 32;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFS   = 8'h00;
    localparam logic [7:0] STATUS_OFFS = 8'h04;
    localparam logic [7:0] LEDS_OFFS   = 8'h08;
    localparam logic [2:0] CTRL_RESET  = 3'h0;
    localparam int unsigned CTRL_CONFIGURED_BIT = 0;
    localparam int unsigned CTRL_DISABLE_BIT    = 1;
    localparam int unsigned CTRL_LOW_POWER_BIT  = 2;
    localparam int unsigned STAT_POWERUP_BIT    = 0;
    localparam int unsigned STAT_ADDR_BIT       = 1;
    localparam int unsigned STAT_RUN_BIT        = 2;
    localparam int unsigned STAT_ADDR_LSB       = 8;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic                power;
        logic                fault;
        logic [NUM_CHAN-1:0] red;
        logic [NUM_CHAN-1:0] amber;
    } ledseq_leds_s;

    typedef struct packed {
        logic                watchdog_fail;
        logic [NUM_CHAN-1:0] active;
        logic [NUM_CHAN-1:0] fault;
        logic [NUM_CHAN-1:0] unconfigured;
    } ledseq_chan_s;

    typedef enum logic [2:0] {
        SEQ_POWERUP,
        SEQ_RED_ON,
        SEQ_RED_OFF,
        SEQ_AMB_ON,
        SEQ_AMB_OFF,
        SEQ_ADDR,
        SEQ_RUN
    } ledseq_state_e;

endpackage : ledseq_pkg

// *** hdl/ledseq_timer.sv ***
// Interval timer that pulses once every limit cycles.
`timescale 1ns/1ps
module ledseq_timer #(
    parameter int unsigned W = 32
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] limit,
    output logic              tick
);
    logic [W-1:0] cnt_q;
    logic         tick_q;
    wire  logic   at_end = (cnt_q >= limit - W'(1));

    // The compare is >= so a shrinking limit never lets the count run away.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else if (ce) begin
            cnt_q  <= at_end ? '0 : cnt_q + W'(1);
            tick_q <= at_end;
        end
    end

    assign tick = tick_q;
endmodule : ledseq_timer

// *** hdl/ledseq_top.sv ***
// Front-panel LED sequencer with lamp test, address display and status display.
`timescale 1ns/1ps
// What this block does
// - Drives eighteen LEDs: device power, device fault, eight red, eight amber.
// - After reset, device power and fault LEDs light before the channel test.
// - Red channel LEDs turn on one by one, channel 1 to 8, staying lit.
// - After channel 8 red lights, reds turn off one by one, 1 to 8.
// - Amber channel LEDs then get the same ascending on-then-off walk.
// - Address switches then show on red LEDs, switch n on channel n.
// - The address pattern stays for two seconds.
// - Device fault LED turns off when address display ends.
// - Afterwards show unconfigured or normal display per configuration status.
// - Unconfigured display flashes all eight amber LEDs together.
// - Device power LED is lit whenever powered.
// - Device fault LED steady when disabled or watchdog failed.
// - Device fault LED stays steadily lit through the whole power-up sequence.
// - Normal display: red LED steady while channel input closed or output active.
// - Amber LED blinks on low power or channel not configured.
// - Amber LED steady while channel reports a fault.
module ledseq_top #(
    parameter int unsigned STEP_CYCLES  = ledseq_pkg::STEP_CYC,
    parameter int unsigned BLINK_CYCLES = ledseq_pkg::BLINK_CYC,
    parameter int unsigned ADDR_CYCLES  = ledseq_pkg::ADDR_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    input  wire logic                    ce,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    input  wire logic [7:0]              addr_switch,
    input  wire ledseq_pkg::ledseq_chan_s chan_status,
    output ledseq_pkg::ledseq_leds_s     leds
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] mask_upto(input logic [2:0] idx);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            m[i] = (3'(i) <= idx);
        end
        return m;
    endfunction : mask_upto

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    ledseq_pkg::ledseq_state_e state_q;
    ledseq_pkg::ledseq_state_e state_d;
    logic [2:0]                idx_q;
    logic [2:0]                idx_d;
    logic [7:0]                sw_meta_q;
    logic [7:0]                sw_sync_q;
    logic [7:0]                addr_q;
    logic                      blink_q;
    logic [2:0]                ctrl_q;
    logic                      ack_q;
    logic [31:0]               rdata_q;
    ledseq_pkg::ledseq_leds_s  leds_q;
    ledseq_pkg::ledseq_leds_s  leds_d;
    logic                      step_tick;
    logic                      blink_tick;

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    // Long counts are parameters so that simulation can shorten them.
    wire logic [31:0] seq_limit = (state_q == ledseq_pkg::SEQ_ADDR)
                                  ? ADDR_CYCLES : STEP_CYCLES;

    ledseq_timer #(.W(ledseq_pkg::TMR_W)) u_step_timer (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .limit   (seq_limit),
        .tick    (step_tick)
    );

    ledseq_timer #(.W(ledseq_pkg::TMR_W)) u_blink_timer (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .limit   (BLINK_CYCLES),
        .tick    (blink_tick)
    );

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    wire logic walk_state = (state_q == ledseq_pkg::SEQ_RED_ON)
                          || (state_q == ledseq_pkg::SEQ_RED_OFF)
                          || (state_q == ledseq_pkg::SEQ_AMB_ON)
                          || (state_q == ledseq_pkg::SEQ_AMB_OFF);
    wire logic walk_last  = walk_state && (idx_q == 3'h7);

    always_comb begin
        state_d = state_q;
        idx_d   = idx_q;
        if (step_tick) begin
            if (walk_state && !walk_last) begin
                idx_d = idx_q + 3'h1;
            end else begin
                idx_d = 3'h0;
                case (state_q)
                    ledseq_pkg::SEQ_POWERUP: state_d = ledseq_pkg::SEQ_RED_ON;
                    ledseq_pkg::SEQ_RED_ON:  state_d = ledseq_pkg::SEQ_RED_OFF;
                    ledseq_pkg::SEQ_RED_OFF: state_d = ledseq_pkg::SEQ_AMB_ON;
                    ledseq_pkg::SEQ_AMB_ON:  state_d = ledseq_pkg::SEQ_AMB_OFF;
                    ledseq_pkg::SEQ_AMB_OFF: state_d = ledseq_pkg::SEQ_ADDR;
                    ledseq_pkg::SEQ_ADDR:    state_d = ledseq_pkg::SEQ_RUN;
                    ledseq_pkg::SEQ_RUN:     state_d = ledseq_pkg::SEQ_RUN;
                    default:                 state_d = ledseq_pkg::SEQ_POWERUP;
                endcase
            end
        end
    end

    wire logic enter_addr = (state_q == ledseq_pkg::SEQ_AMB_OFF)
                          && (state_d == ledseq_pkg::SEQ_ADDR);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= ledseq_pkg::SEQ_POWERUP;
            idx_q   <= 3'h0;
        end else if (ce) begin
            state_q <= state_d;
            idx_q   <= idx_d;
        end
    end

    // The first stage feeds only the second; the address is latched once.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sw_meta_q <= 8'h00;
            sw_sync_q <= 8'h00;
            addr_q    <= 8'h00;
        end else if (ce) begin
            sw_meta_q <= addr_switch;
            sw_sync_q <= sw_meta_q;
            if (enter_addr) begin
                addr_q <= sw_sync_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            blink_q <= 1'b0;
        end else if (ce && blink_tick) begin
            blink_q <= !blink_q;
        end
    end

    // ------------------------------------------------------------
    // LED drive
    // ------------------------------------------------------------
    wire logic       sw_configured = ctrl_q[ledseq_pkg::CTRL_CONFIGURED_BIT];
    wire logic       sw_disable    = ctrl_q[ledseq_pkg::CTRL_DISABLE_BIT];
    wire logic       low_power     = ctrl_q[ledseq_pkg::CTRL_LOW_POWER_BIT];
    wire logic       dev_bad       = sw_disable || chan_status.watchdog_fail;
    wire logic [7:0] walk_mask     = mask_upto(idx_q);
    wire logic [7:0] blink_vec     = {8{blink_q}};
    wire logic [7:0] amber_run     = chan_status.fault
                                   | ((chan_status.unconfigured
                                       | {8{low_power}}) & blink_vec);

    always_comb begin
        leds_d       = '0;
        leds_d.power = 1'b1;
        leds_d.fault = 1'b1;
        case (state_q)
            ledseq_pkg::SEQ_POWERUP: leds_d.red   = 8'h00;
            ledseq_pkg::SEQ_RED_ON:  leds_d.red   = walk_mask;
            ledseq_pkg::SEQ_RED_OFF: leds_d.red   = ~walk_mask;
            ledseq_pkg::SEQ_AMB_ON:  leds_d.amber = walk_mask;
            ledseq_pkg::SEQ_AMB_OFF: leds_d.amber = ~walk_mask;
            ledseq_pkg::SEQ_ADDR:    leds_d.red   = addr_q;
            ledseq_pkg::SEQ_RUN: begin
                leds_d.fault = dev_bad;
                if (sw_configured) begin
                    leds_d.red   = chan_status.active;
                    leds_d.amber = amber_run;
                end else begin
                    leds_d.amber = blink_vec;
                end
            end
            default: leds_d.red = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            leds_q <= '0;
        end else if (ce) begin
            leds_q <= leds_d;
        end
    end

    assign leds = leds_q;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    wire logic        bus_req   = wb_cyc_i && wb_stb_i && !ack_q;
    wire logic        hit_ctrl  = (wb_adr_i == ledseq_pkg::CTRL_OFFS);
    wire logic        hit_stat  = (wb_adr_i == ledseq_pkg::STATUS_OFFS);
    wire logic        hit_leds  = (wb_adr_i == ledseq_pkg::LEDS_OFFS);
    wire logic        ctrl_wr   = bus_req && wb_we_i && hit_ctrl && wb_sel_i[0];
    wire logic        in_pwrup  = (state_q != ledseq_pkg::SEQ_RUN);
    wire logic [31:0] stat_word = {16'h0000, addr_q, 5'h00,
                                   (state_q == ledseq_pkg::SEQ_RUN),
                                   (state_q == ledseq_pkg::SEQ_ADDR),
                                   in_pwrup};
    wire logic [31:0] leds_word = {14'h0000, leds_q};
    wire logic [31:0] rdata_d   = hit_ctrl ? {29'h0, ctrl_q}
                                : hit_stat ? stat_word
                                : hit_leds ? leds_word
                                : 32'h0000_0000;

    // Unmapped addresses still acknowledge, reading zero and dropping writes.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
            ctrl_q  <= ledseq_pkg::CTRL_RESET;
        end else if (ce) begin
            ack_q   <= bus_req;
            rdata_q <= bus_req ? rdata_d : 32'h0000_0000;
            if (ctrl_wr) begin
                ctrl_q <= wb_dat_i[2:0];
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
endmodule : ledseq_top
